// ### core/ssb_addressing.sv
// shared-bus sent addressing: pulse decode, slot counting and response timing
`timescale 1ns/100ps
module ssb_addressing #(
   parameter int MIN_RESP_CYCLES = ssb_pkg::RESP_MIN_CYC // least cycles, pulse rise to sync end
) (
   input wire logic i_clock,                        // 200 MHz clock
   input wire logic i_nrst,                         // asynchronous reset, active low
   input wire logic i_clk_en,                       // freezes all state while low
   input wire logic i_line,                         // shared bus level, from the pin
   input wire logic [1:0] i_sensor_ident,           // own identifier
   input wire logic [2:0] i_out_mode,               // output mode code
   input wire logic [4:0] i_tick_code,              // tick time code
   input wire ssb_pkg::ssb_reg_req_t i_reg,         // register access
   output logic [31:0] o_reg_rdata,                 // read data of addressed register
   output ssb_pkg::ssb_resp_t o_resp,               // frame start and sample strobes
   output logic [1:0] o_slot_counter,               // current slot counter
   output logic o_offline                           // device is offline
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic line;
      logic [11:0] pre;
      logic [7:0] low_ticks;
      logic [9:0] high_ticks;
      logic [14:0] cyc;
      ssb_pkg::ssb_st_t st;
      logic [1:0] slot;
      logic [1:0] slot_no;
      logic [2:0] inc_cnt;
      logic offline;
      logic off_cont;
      logic held_valid;
      ssb_pkg::ssb_cfg_t cfg;
      logic [31:0] rdata;
      ssb_pkg::ssb_resp_t resp;
   } ssb_core_t;

   ssb_core_t state;
   ssb_core_t next_state;
   logic [1:0] sync_nrst_pipe;
   logic sync_nrst;
   logic rise;
   logic fall;
   logic tick;
   logic sequential_polling_mode;
   logic addressed_polling_mode;
   logic addr_ev;
   logic resp_ok;
   logic collect_end;
   logic hold_allowed;
   logic [1:0] mark_est;
   logic [1:0] next_slot;
   logic [9:0] resp_delay;
   logic [11:0] tick_cyc;
   logic [16:0] sync_cyc;
   logic [16:0] min_cyc;
   logic [14:0] thr_cyc;
   ssb_pkg::ssb_fn_t func;
   ssb_pkg::ssb_stat_t stat;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         sync_nrst_pipe <= 2'h0;
      else
         sync_nrst_pipe <= {sync_nrst_pipe[0], 1'b1};
   end

   assign sync_nrst = sync_nrst_pipe[1];

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   assign sequential_polling_mode = (i_out_mode == ssb_pkg::MODE_LONG) || (i_out_mode == ssb_pkg::MODE_SHORT);
   assign addressed_polling_mode = (i_out_mode == ssb_pkg::MODE_ADDR);
   assign tick_cyc = ssb_pkg::tick_cycles(i_tick_code);
   assign next_slot = (state.slot == state.cfg.max_sensor) ? 2'h0 : state.slot + 2'h1;
   assign hold_allowed = !state.cfg.no_sample || state.cfg.zero_sample;
   // fast ticks stretch the gap so the sync pulse ends late enough for processing
   assign sync_cyc = ssb_pkg::SYNC_TICKS * {5'h00, tick_cyc};
   assign min_cyc = 17'(MIN_RESP_CYCLES);
   assign thr_cyc = (sync_cyc >= min_cyc) ? 15'h0000 : 15'(min_cyc - sync_cyc);
   assign resp_delay = state.cfg.slot_marking ? ssb_pkg::mark_delay(i_sensor_ident)
                                              : ssb_pkg::RESP_MIN_TICKS;
   assign resp_ok = state.line && (state.high_ticks >= resp_delay)
                    && (state.cyc >= thr_cyc);
   assign collect_end = state.line && (state.high_ticks == ssb_pkg::ADDR_END_TICKS);
   assign mark_est = (state.high_ticks < ssb_pkg::MARK_EDGE_1) ? 2'h0 :
                     (state.high_ticks < ssb_pkg::MARK_EDGE_2) ? 2'h1 :
                     (state.high_ticks < ssb_pkg::MARK_EDGE_3) ? 2'h2 : 2'h3;

   // function from the measured low width
   always_comb
   begin
      func = ssb_pkg::FN_NONE;
      if (i_out_mode == ssb_pkg::MODE_LONG)
      begin
         if (ssb_pkg::in_win(state.low_ticks, ssb_pkg::LG_OUT_MIN, ssb_pkg::LG_OUT_MAX))
            func = ssb_pkg::FN_OUT;
         else if (ssb_pkg::in_win(state.low_ticks, ssb_pkg::LG_SYNC_MIN, ssb_pkg::LG_SYNC_MAX))
            func = ssb_pkg::FN_SYNC;
      end
      else if (i_out_mode == ssb_pkg::MODE_SHORT || addressed_polling_mode)
      begin
         if (ssb_pkg::in_win(state.low_ticks, ssb_pkg::SH_OUT_MIN, ssb_pkg::SH_OUT_MAX))
            func = ssb_pkg::FN_OUT;
         else if (ssb_pkg::in_win(state.low_ticks, ssb_pkg::SH_SAMP_MIN, ssb_pkg::SH_SAMP_MAX))
            func = ssb_pkg::FN_SAMP;
         else if (!addressed_polling_mode && ssb_pkg::in_win(state.low_ticks, ssb_pkg::SH_SYNC_MIN,
                                            ssb_pkg::SH_SYNC_MAX))
            func = ssb_pkg::FN_SYNC;
         else if (addressed_polling_mode && ssb_pkg::in_win(state.low_ticks, ssb_pkg::INC_MIN, ssb_pkg::INC_MAX))
            func = ssb_pkg::FN_INC;
      end
   end

   assign addr_ev = rise && ((func == ssb_pkg::FN_OUT)
                    || (func == ssb_pkg::FN_SAMP && state.cfg.fsample_adr));

   always_comb
   begin
      stat = '0;
      stat.st = state.st;
      stat.held_valid = state.held_valid;
      stat.off_cont = state.off_cont;
      stat.offline = state.offline;
      stat.slot = state.slot;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_state.resp = '0;
      // s1 is only ever read by s2
      next_state.s1 = i_line;
      next_state.s2 = state.s1;
      next_state.s3 = state.s2;
      rise = 1'b0;
      fall = 1'b0;
      if (state.s2 == state.s3 && state.s3 != state.line)
      begin
         next_state.line = state.s3;
         rise = state.s3;
         fall = !state.s3;
      end

      // tick prescaler restarts on each edge so widths count from the edge
      tick = (state.pre == tick_cyc - 12'h001);
      if (tick || rise || fall)
         next_state.pre = '0;
      else
         next_state.pre = state.pre + 12'h001;

      if (fall)
         next_state.low_ticks = '0;
      else if (!state.line && tick && state.low_ticks != 8'hFF)
         next_state.low_ticks = state.low_ticks + 8'h01;

      if (rise)
      begin
         next_state.high_ticks = '0;
         next_state.cyc = '0;
      end
      else if (state.line)
      begin
         if (tick && state.high_ticks != 10'h3FF)
            next_state.high_ticks = state.high_ticks + 10'h001;
         if (state.cyc != 15'h7FFF)
            next_state.cyc = state.cyc + 15'h0001;
      end

      // sequential polling pulses
      if (rise && sequential_polling_mode)
      begin
         case (func)
            ssb_pkg::FN_OUT, ssb_pkg::FN_SAMP:
            begin
               if (func == ssb_pkg::FN_SAMP && !state.cfg.no_sample)
                  next_state.resp.sample_hold = 1'b1;
               if (func == ssb_pkg::FN_OUT && state.cfg.zero_sample && state.slot == 2'h0)
                  next_state.resp.sample_hold = 1'b1;
               next_state.st = ssb_pkg::ST_IDLE;
               if (addr_ev)
               begin
                  next_state.slot = next_slot;
                  next_state.slot_no = state.slot;
                  if (!state.offline && state.slot == i_sensor_ident)
                     next_state.st = ssb_pkg::ST_WAIT;
                  else if (state.cfg.slot_marking)
                     next_state.st = ssb_pkg::ST_MARK;
               end
            end
            ssb_pkg::FN_SYNC:
            begin
               next_state.slot = 2'h0;
               next_state.offline = 1'b0;
               next_state.off_cont = 1'b0;
               next_state.st = ssb_pkg::ST_IDLE;
            end
            default:
            begin
               next_state.st = state.st;
            end
         endcase
      end

      // addressed polling pulses
      if (rise && addressed_polling_mode)
      begin
         if (state.st == ssb_pkg::ST_COLLECT && func == ssb_pkg::FN_INC)
         begin
            if (state.inc_cnt != 3'h4)
               next_state.inc_cnt = state.inc_cnt + 3'h1;
         end
         else if (func == ssb_pkg::FN_OUT || func == ssb_pkg::FN_SAMP)
         begin
            if (func == ssb_pkg::FN_SAMP && !state.cfg.no_sample)
               next_state.resp.sample_hold = 1'b1;
            next_state.inc_cnt = 3'h0;
            next_state.st = addr_ev ? ssb_pkg::ST_COLLECT : ssb_pkg::ST_IDLE;
         end
      end

      case (state.st)
         ssb_pkg::ST_COLLECT:
         begin
            if (collect_end)
               next_state.st = (state.inc_cnt == {1'b0, i_sensor_ident}) ? ssb_pkg::ST_WAIT
                                                                          : ssb_pkg::ST_IDLE;
         end
         ssb_pkg::ST_WAIT:
         begin
            // a host pulse during the gap cancels the answer
            if (fall)
               next_state.st = ssb_pkg::ST_IDLE;
            else if (resp_ok)
            begin
               next_state.resp.frame_start = 1'b1;
               next_state.resp.frame_held = state.held_valid;
               next_state.held_valid = 1'b0;
               next_state.st = ssb_pkg::ST_IDLE;
            end
         end
         ssb_pkg::ST_MARK:
         begin
            if (state.line && state.high_ticks > ssb_pkg::MARK_TIMEOUT)
               next_state.st = ssb_pkg::ST_IDLE;
            else if (fall)
            begin
               if (state.offline && !state.off_cont && state.cfg.slot_sync)
               begin
                  next_state.slot = (mark_est == state.cfg.max_sensor) ? 2'h0
                                                                       : mark_est + 2'h1;
                  next_state.offline = 1'b0;
               end
               else if (!state.offline && mark_est != state.slot_no)
               begin
                  next_state.offline = 1'b1;
                  next_state.off_cont = 1'b1;
               end
               next_state.st = ssb_pkg::ST_IDLE;
            end
         end
         default:
         begin
            next_state.st = next_state.st;
         end
      endcase

      // only power-up can make a bus stay high this long once polling runs
      if (sequential_polling_mode && state.cfg.idle_sync && state.line && tick
          && state.high_ticks == ssb_pkg::IDLE_TICKS)
      begin
         next_state.slot = 2'h0;
         next_state.offline = 1'b0;
         next_state.off_cont = 1'b0;
      end

      if (next_state.resp.sample_hold)
         next_state.held_valid = 1'b1;

      // registers
      next_state.rdata = '0;
      if (i_reg.addr == ssb_pkg::CFG_ADDR)
         next_state.rdata = state.cfg & ssb_pkg::CFG_MASK;
      else if (i_reg.addr == ssb_pkg::STAT_ADDR)
         next_state.rdata = stat;
      if (i_reg.wr && i_reg.addr == ssb_pkg::CFG_ADDR)
         next_state.cfg = ssb_pkg::ssb_cfg_t'(i_reg.wdata & ssb_pkg::CFG_MASK);
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge sync_nrst)
   begin
      if (!sync_nrst)
      begin
         state <= '0;
         state.s1 <= 1'b1;
         state.s2 <= 1'b1;
         state.s3 <= 1'b1;
         state.line <= 1'b1;
         state.cfg <= ssb_pkg::CFG_RESET;
         state.offline <= ssb_pkg::CFG_RESET[22];
      end
      else if (i_clk_en)
      begin
         state <= next_state;
      end
   end

   assign o_reg_rdata = state.rdata;
   assign o_resp = state.resp;
   assign o_slot_counter = state.slot;
   assign o_offline = state.offline;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!sync_nrst);

   slot_count_a:
   assert property (i_clk_en && sequential_polling_mode && addr_ev && state.slot != state.cfg.max_sensor
                    |=> state.slot == $past(state.slot) + 2'h1)
      else $error("slot counter did not advance on addressing pulse");

   slot_wrap_a:
   assert property (i_clk_en && sequential_polling_mode && addr_ev && state.slot == state.cfg.max_sensor
                    |=> state.slot == 2'h0)
      else $error("slot counter did not wrap to zero");

   bcast_keep_a:
   assert property (i_clk_en && sequential_polling_mode && rise && func == ssb_pkg::FN_SAMP
                    && !state.cfg.fsample_adr |=> $stable(state.slot))
      else $error("broadcast pulse changed slot counter");

   resync_zero_a:
   assert property (i_clk_en && sequential_polling_mode && rise && func == ssb_pkg::FN_SYNC
                    |=> state.slot == 2'h0 && !state.offline)
      else $error("resync pulse did not restart slots");

   frame_gate_a:
   assert property ($rose(o_resp.frame_start) |-> $past(state.st) == ssb_pkg::ST_WAIT)
      else $error("frame started without being addressed");

   resp_gap_a:
   assert property (i_clk_en && state.st == ssb_pkg::ST_WAIT && !resp_ok
                    |=> !o_resp.frame_start)
      else $error("frame started before the high gap elapsed");

   mark_offline_a:
   assert property (i_clk_en && state.st == ssb_pkg::ST_MARK && fall && !state.offline
                    && state.high_ticks <= ssb_pkg::MARK_TIMEOUT
                    && mark_est != state.slot_no |=> state.offline && state.off_cont)
      else $error("marking mismatch did not take device offline");

   idle_zero_a:
   assert property (i_clk_en && sequential_polling_mode && state.cfg.idle_sync && state.line && tick
                    && state.high_ticks == ssb_pkg::IDLE_TICKS |=> state.slot == 2'h0)
      else $error("idle bus did not clear slot counter");

   no_hold_a:
   assert property ($rose(o_resp.sample_hold) |-> $past(hold_allowed))
      else $error("sample held while sampling is disabled");

   width_ignore_a:
   assert property (i_clk_en && rise && func == ssb_pkg::FN_NONE |=> $stable(state.slot))
      else $error("unknown pulse width moved slot counter");

   addr_match_a:
   assert property (i_clk_en && addressed_polling_mode && state.st == ssb_pkg::ST_COLLECT && collect_end
                    && state.inc_cnt != {1'b0, i_sensor_ident} |=> state.st == ssb_pkg::ST_IDLE)
      else $error("answered with wrong increment count");

endmodule

// ### core/ssb_pkg.sv
// shared-bus sent addressing: constants, register layout and carrier types
//
// Overview of operation
// - count slot on every addressing pulse in sequential polling
// - sequential polling frame request answered only when slot matches
// - slot counter wraps past configured sensor total
// - broadcast pulses leave slot counter untouched
// - resync pulse makes next pulse slot zero
// - slot marking delays response by identifier
// - measured marking mismatch drops device offline
// - slot sync reloads counter from measured slot
// - long idle bus clears slot counter
// - power-up offline option, else online at zero
// - host function chosen by low pulse width
// - hold line high before frame, 70.4ns floor
// - answer held data, else current data
// - zero-slot sampling holds on slot zero output
// - no-sample without zero-slot never holds
// - sample request holds; addressing only if enabled
// - short trigger windows 15-19, 31-39, 93-115
// - long trigger windows 9-81 and 105-171
// - addressed polling counts increments, ends after 18
// - addressed polling answers when increments equal identifier
// - addressed polling windows 15-19, 31-39 and increments 4-8
// - tick length from tick code, below 0.5us unsupported
package ssb_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] CFG_ADDR = 8'h14;
   localparam logic [7:0] STAT_ADDR = 8'h18;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_MASK = 32'h03FB_0000;

   typedef struct packed {
      logic [5:0] rsvd_hi;
      logic zero_sample;
      logic slot_sync;
      logic slot_marking;
      logic por_offline;
      logic idle_sync;
      logic fsample_adr;
      logic no_sample;
      logic rsvd_mid;
      logic [1:0] max_sensor;
      logic [15:0] rsvd_lo;
   } ssb_cfg_t;

   typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_WAIT, ST_MARK} ssb_st_t;
   typedef enum logic [2:0] {FN_NONE, FN_OUT, FN_SAMP, FN_SYNC, FN_INC} ssb_fn_t;

   typedef struct packed {
      logic [24:0] rsvd;
      ssb_st_t st;
      logic held_valid;
      logic off_cont;
      logic offline;
      logic [1:0] slot;
   } ssb_stat_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [31:0] wdata;
   } ssb_reg_req_t;

   typedef struct packed {
      logic frame_start;
      logic frame_held;
      logic sample_hold;
   } ssb_resp_t;

   // ------------------------------------------------------------
   // output modes and pulse windows, in ticks
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_LONG = 3'h3;
   localparam logic [2:0] MODE_SHORT = 3'h4;
   localparam logic [2:0] MODE_ADDR = 3'h5;
   localparam logic [7:0] SH_OUT_MIN = 8'h0F;
   localparam logic [7:0] SH_OUT_MAX = 8'h13;
   localparam logic [7:0] SH_SAMP_MIN = 8'h1F;
   localparam logic [7:0] SH_SAMP_MAX = 8'h27;
   localparam logic [7:0] SH_SYNC_MIN = 8'h5D;
   localparam logic [7:0] SH_SYNC_MAX = 8'h73;
   localparam logic [7:0] LG_OUT_MIN = 8'h09;
   localparam logic [7:0] LG_OUT_MAX = 8'h51;
   localparam logic [7:0] LG_SYNC_MIN = 8'h69;
   localparam logic [7:0] LG_SYNC_MAX = 8'hAB;
   localparam logic [7:0] INC_MIN = 8'h04;
   localparam logic [7:0] INC_MAX = 8'h08;

   localparam logic [9:0] RESP_MIN_TICKS = 10'h007;
   localparam logic [9:0] ADDR_END_TICKS = 10'h012;
   localparam logic [9:0] IDLE_TICKS = 10'h1FE;
   localparam logic [9:0] MARK_TIMEOUT = 10'h05A;
   localparam logic [9:0] MARK_EDGE_1 = 10'h00D;
   localparam logic [9:0] MARK_EDGE_2 = 10'h01B;
   localparam logic [9:0] MARK_EDGE_3 = 10'h031;
   localparam logic [9:0] MARK_DLY_0 = 10'h007;
   localparam logic [9:0] MARK_DLY_1 = 10'h012;
   localparam logic [9:0] MARK_DLY_2 = 10'h024;
   localparam logic [9:0] MARK_DLY_3 = 10'h03E;
   localparam logic [16:0] SYNC_TICKS = 17'h00038;

   // ------------------------------------------------------------
   // clock and time
   // ------------------------------------------------------------
   localparam int CLK_PS = 5000;
   localparam int RESP_MIN_PS = 70400;
   localparam int RESP_MIN_CYC = (RESP_MIN_PS + CLK_PS - 1) / CLK_PS;

   function automatic logic [11:0] tick_cycles(input logic [4:0] code);
      int ps;
      if (code == 5'h00) ps = 1000000;
      else if (code < 5'h03) ps = 500000;
      else if (code <= 5'h17) ps = 500000 + 125000 * (int'(code) - 3);
      else if (code <= 5'h1D) ps = 3500000 + 500000 * (int'(code) - 24);
      else if (code == 5'h1E) ps = 7000000;
      else ps = 10000000;
      return 12'(ps / CLK_PS);
   endfunction

   function automatic logic in_win(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   function automatic logic [9:0] mark_delay(input logic [1:0] ident);
      logic [9:0] d;
      case (ident)
         2'h0: d = MARK_DLY_0;
         2'h1: d = MARK_DLY_1;
         2'h2: d = MARK_DLY_2;
         default: d = MARK_DLY_3;
      endcase
      return d;
   endfunction

endpackage

// ### test/ssb_host_model.sv
// host controller model pulling the shared open-drain line low
`timescale 1ns/100ps
module ssb_host_model #(
   parameter int TICK_CYC = 100 // clock cycles per tick
) (
   input wire logic i_clock, // bench clock
   output logic o_line       // shared line level
);
   initial o_line = 1'b1;
   // a released line returns to its pull-up level, never holds a stale low
   task automatic pulse(input int low_ticks, input int gap_ticks);
      @(negedge i_clock);
      o_line = 1'b0;
      repeat (low_ticks * TICK_CYC) @(negedge i_clock);
      o_line = 1'b1;
      repeat (gap_ticks * TICK_CYC) @(negedge i_clock);
   endtask
endmodule

// ### test/test_ssb_addressing.sv
// self-checking bench for the shared-bus sent addressing block
`timescale 1ns/100ps
module test_ssb_addressing;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic line;
   logic [1:0] ident = 2'h0;
   logic [2:0] mode = ssb_pkg::MODE_SHORT;
   ssb_pkg::ssb_reg_req_t req = '0;
   logic [31:0] rdata;
   ssb_pkg::ssb_resp_t resp;
   logic [1:0] slot;
   logic offline;
   logic last_held = 1'b0;
   int fails = 0;
   int check_count = 0;
   int n_frame = 0;
   int n_hold = 0;

   always #2.5 i_clock = ~i_clock;

   ssb_host_model host (.i_clock(i_clock), .o_line(line));

   // response floor above the 15-cycle default, still under the 5600-cycle sync pulse so the gap is not stretched
   ssb_addressing #(.MIN_RESP_CYCLES(200)) dut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(1'b1), .i_line(line),
      .i_sensor_ident(ident), .i_out_mode(mode), .i_tick_code(5'h03),
      .i_reg(req), .o_reg_rdata(rdata), .o_resp(resp),
      .o_slot_counter(slot), .o_offline(offline));

   always @(posedge i_clock)
   begin
      if (resp.frame_start === 1'b1)
      begin
         n_frame++;
         last_held <= resp.frame_held;
      end
      if (resp.sample_hold === 1'b1)
         n_hold++;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(input logic [31:0] d);
      @(negedge i_clock);
      req = '{addr: ssb_pkg::CFG_ADDR, wr: 1'b1, wdata: d};
      @(negedge i_clock);
      req.wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge i_clock);
      req.addr = a;
      @(negedge i_clock);
      d = rdata;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_regs;
      logic [31:0] d;
      reg_rd(ssb_pkg::CFG_ADDR, d);
      check(d, ssb_pkg::CFG_RESET);
      check({30'h0, offline, slot}, 32'h0);
      reg_wr(32'hFFFF_FFFF);
      reg_rd(ssb_pkg::CFG_ADDR, d);
      check(d, ssb_pkg::CFG_MASK);
      reg_rd(8'h40, d);
      check(d, 32'h0);
      $display("test_regs done");
   endtask

   task automatic test_sequential;
      reg_wr(32'h0002_0000);
      host.pulse(17, 12);
      check(n_frame, 1);
      check(slot, 2'h1);
      host.pulse(35, 12);
      check(n_hold, 1);
      check(n_frame, 1);
      check(slot, 2'h1);
      host.pulse(25, 12);
      check(slot, 2'h1);
      host.pulse(104, 12);
      check(slot, 2'h0);
      host.pulse(17, 12);
      check(n_frame, 2);
      check(last_held, 1'b1);
      host.pulse(17, 12);
      host.pulse(17, 12);
      check(n_frame, 2);
      check(slot, 2'h0);
      $display("test_sequential done");
   endtask

   task automatic test_long;
      mode = ssb_pkg::MODE_LONG;
      host.pulse(60, 12);
      check(n_frame, 3);
      check(slot, 2'h1);
      host.pulse(140, 12);
      check(slot, 2'h0);
      $display("test_long done");
   endtask

   task automatic test_addressed;
      mode = ssb_pkg::MODE_ADDR;
      ident = 2'h1;
      host.pulse(17, 6);
      host.pulse(6, 25);
      check(n_frame, 4);
      host.pulse(17, 25);
      check(n_frame, 4);
      $display("test_addressed done");
   endtask

   task automatic test_marking;
      logic [31:0] d;
      mode = ssb_pkg::MODE_SHORT;
      ident = 2'h0;
      reg_wr(32'h0282_0000);
      host.pulse(17, 12);
      check(n_hold, 2);
      check(n_frame, 5);
      check(last_held, 1'b1);
      host.pulse(17, 12);
      host.pulse(25, 12);
      check(offline, 1'b1);
      reg_rd(ssb_pkg::STAT_ADDR, d);
      check(d, 32'h0000_000E);
      ident = 2'h1;
      host.pulse(95, 12);
      check({30'h0, offline, slot}, 32'h0);
      host.pulse(17, 12);
      host.pulse(17, 14);
      check(n_frame, 5);
      check(offline, 1'b0);
      $display("test_marking done");
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic print_verdict;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (100000) @(posedge i_clock);
      fails++;
      print_verdict;
   end

   initial
   begin
      repeat (4) @(negedge i_clock);
      i_nrst = 1'b1;
      repeat (3) @(negedge i_clock);
      test_regs;
      test_sequential;
      test_long;
      test_addressed;
      test_marking;
      print_verdict;
   end
endmodule
